// [ots_far_side.sv]
// Far-side model of the machine limit switches.
`timescale 1ns/1ps
`default_nettype none
module ots_far_side (
   input wire logic fwd_at_end,
   input wire logic rev_at_end,
   output logic forward_limit_input,
   output logic reverse_limit_input
);
   // Normally closed switches, so a broken wire also reads as overtravel.
   assign forward_limit_input = !fwd_at_end;
   assign reverse_limit_input = !rev_at_end;
endmodule // ots_far_side
`default_nettype wire

// [ots_overtravel.sv]
// Overtravel limit handling, stop method selection and warning latch.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Forward selector 8 ignores forward limit.
// - Reverse selector 8 ignores reverse limit.
// - Digits 1,2 torque-limited stop, hold/free.
// - Digits 3,4 timed ramp, hold/free.
// - Torque mode uses brake or coast only.
// - Estop torque 0..800, default 800, immediate.
// - Applied estop torque clamped to motor maximum.
// - Decel time 0..10000 ms, default 0.
// - Zero decel time gives zero-speed stop.
// - Ramp time spans maximum speed to zero.
// - Warning detection only when enable digit set.
// - Latch warning on entering overtravel, even briefly.
// - Warning detected only while servo on.
// - Warning never changes stop behaviour.
// - With command, only commanded direction warns.
// - Without command, either direction warns.
// - Servo-on while in overtravel gives no warning.
// - Warning released only by alarm clear.
// - After clear, rearm only once overtravel released.
// - Soft limit does not suppress the warning.
module ots_overtravel
   import ots_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic power_restart,
   input wire ots_cfg_type cfg_pending,
   input wire logic [9:0] emergency_stop_torque_param,
   input wire logic [13:0] stop_decel_time_param,
   input wire logic [9:0] motor_max_torque,
   input wire logic [15:0] motor_max_speed,
   input wire logic [15:0] motor_speed,
   input wire logic forward_limit_input,
   input wire logic reverse_limit_input,
   input wire logic servo_on,
   input wire logic torque_mode,
   input wire logic cmd_fwd,
   input wire logic cmd_rev,
   input wire logic soft_limit,
   input wire logic alarm_clear_command,
   output ots_cfg_type cfg_active,
   output logic fwd_allowed,
   output logic rev_allowed,
   output ots_stop_type stop_cmd,
   output logic warn_active,
   output logic [15:0] warn_code
);

   logic fwd_ot;
   logic rev_ot;
   logic ot_any;
   logic warn_event;
   logic rearm_block;
   logic servo_on_d;
   logic fwd_ot_d;
   logic rev_ot_d;
   logic [16:0] tick_cnt;
   logic tick;
   logic [15:0] ramp_speed;
   logic [15:0] ramp_step;
   logic [9:0] torq_set;
   ots_stop_type next_stop;

   // Selectors copy in only on power restart so a live edit cannot
   // change the stop behaviour in the middle of motion.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_active <= '{OTS_FWD_LIMIT_HONOUR, OTS_REV_LIMIT_HONOUR,
                         OTS_SOFF_DB, OTS_OT_FOLLOW, OTS_WARN_OFF};
      end else if (power_restart) begin
         cfg_active <= cfg_pending;
      end
   end

   // Limit inputs are active while travel is permitted; ignore code skips.
   assign fwd_ot = (cfg_active.fwd_sel != OTS_LIMIT_IGNORE) &&
                   !forward_limit_input;
   assign rev_ot = (cfg_active.rev_sel != OTS_LIMIT_IGNORE) &&
                   !reverse_limit_input;
   assign ot_any = fwd_ot || rev_ot;

   // Drive permissions per direction.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fwd_allowed <= 1'b1;
         rev_allowed <= 1'b1;
      end else begin
         fwd_allowed <= !fwd_ot;
         rev_allowed <= !rev_ot;
      end
   end

   // Emergency torque setting, capped at its range and immediate.
   assign torq_set = (emergency_stop_torque_param > OTS_ESTOP_TORQ_MAX) ?
                     OTS_ESTOP_TORQ_MAX : emergency_stop_torque_param;

   // One millisecond tick from the system clock.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (tick_cnt == OTS_TICK_LAST);
         tick_cnt <= (tick_cnt == OTS_TICK_LAST) ? '0 : tick_cnt + 17'h00001;
      end
   end

   // Per-ms step: max speed divided by the decel time; coarse, and
   // the divide truncates, so the ramp can run slightly past the set time.
   assign ramp_step = (stop_decel_time_param == OTS_DECEL_TIME_ZERO) ?
      motor_max_speed :
      16'(motor_max_speed / ((stop_decel_time_param > OTS_DECEL_TIME_MAX) ?
          OTS_DECEL_TIME_MAX : stop_decel_time_param));

   // Ramp speed reference follows the motor until overtravel, then falls.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ramp_speed <= OTS_SPEED_ZERO;
      end else if (!ot_any) begin
         ramp_speed <= motor_speed;
      end else if (tick) begin
         ramp_speed <= (ramp_speed > ramp_step) ?
                       ramp_speed - ramp_step : OTS_SPEED_ZERO;
      end
   end

   // Stop method selection; the warning latch never feeds into this.
   always_comb begin
      next_stop.act = OTS_ACT_RUN;
      next_stop.hold_zero = 1'b0;
      next_stop.torque_limit = (torq_set > motor_max_torque) ?
                               motor_max_torque : torq_set;
      next_stop.speed_ref = OTS_SPEED_ZERO;
      if (ot_any) begin
         if (torque_mode || cfg_active.ot_stop == OTS_OT_FOLLOW) begin
            next_stop.act = (cfg_active.soff_stop == OTS_SOFF_COAST) ?
                            OTS_ACT_COAST : OTS_ACT_DB;
         end else if (cfg_active.ot_stop == OTS_OT_TORQ_HOLD ||
                      cfg_active.ot_stop == OTS_OT_TORQ_FREE) begin
            next_stop.act = OTS_ACT_TORQ;
            next_stop.hold_zero =
               (cfg_active.ot_stop == OTS_OT_TORQ_HOLD);
         end else begin
            next_stop.act = (stop_decel_time_param == OTS_DECEL_TIME_ZERO) ?
                            OTS_ACT_ZSPD : OTS_ACT_RAMP;
            // A zero-speed stop commands standstill at once, with no ramp.
            if (stop_decel_time_param != OTS_DECEL_TIME_ZERO) begin
               next_stop.speed_ref = ramp_speed;
            end
            next_stop.hold_zero =
               (cfg_active.ot_stop == OTS_OT_TIME_HOLD);
         end
      end
   end

   // Registered stop command.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stop_cmd <= '{OTS_ACT_RUN, 1'b0, OTS_ESTOP_TORQ_RESET,
                       OTS_SPEED_ZERO};
      end else begin
         stop_cmd <= next_stop;
      end
   end

   // Entry into overtravel qualified by command direction; a rising edge
   // of the condition catches even a one-cycle limit pulse. Servo-on
   // edges are excluded so turning on inside overtravel stays silent.
   assign warn_event = (cfg_active.warn_en != OTS_WARN_OFF) && servo_on &&
      servo_on_d && !rearm_block &&
      ((fwd_ot && !fwd_ot_d && (cmd_fwd || !cmd_rev)) ||
       (rev_ot && !rev_ot_d && (cmd_rev || !cmd_fwd)));

   // Edge history of servo and limits.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         servo_on_d <= 1'b0;
         fwd_ot_d <= 1'b0;
         rev_ot_d <= 1'b0;
      end else begin
         servo_on_d <= servo_on;
         fwd_ot_d <= fwd_ot;
         rev_ot_d <= rev_ot;
      end
   end

   // Clearing inside overtravel blocks rearm until the limit releases.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rearm_block <= 1'b0;
      end else if (alarm_clear_command && ot_any) begin
         rearm_block <= 1'b1;
      end else if (!ot_any) begin
         rearm_block <= 1'b0;
      end
   end

   // Sticky warning; a new event in the clear cycle wins.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         warn_active <= 1'b0;
         warn_code <= '0;
      end else if (warn_event) begin
         warn_active <= 1'b1;
         warn_code <= OTS_WARN_CODE;
      end else if (alarm_clear_command) begin
         warn_active <= 1'b0;
         warn_code <= '0;
      end
   end

   property p_fwd_ignore;
      @(posedge clk_sys) disable iff (rst)
      (cfg_active.fwd_sel == OTS_LIMIT_IGNORE) |=> fwd_allowed;
   endproperty
   a_fwd_ignore: assert property (p_fwd_ignore)
      else $error("forward drive blocked while ignored");

   property p_rev_block;
      @(posedge clk_sys) disable iff (rst)
      (cfg_active.rev_sel != OTS_LIMIT_IGNORE && !reverse_limit_input)
      |=> !rev_allowed;
   endproperty
   a_rev_block: assert property (p_rev_block)
      else $error("reverse drive allowed in overtravel");

   property p_torque_mode;
      @(posedge clk_sys) disable iff (rst)
      (torque_mode && ot_any) |=> (stop_cmd.act == OTS_ACT_DB ||
                                   stop_cmd.act == OTS_ACT_COAST);
   endproperty
   a_torque_mode: assert property (p_torque_mode)
      else $error("torque mode used a decelerating stop");

   property p_clamp;
      @(posedge clk_sys) disable iff (rst)
      1'b1 |=> stop_cmd.torque_limit <= $past(motor_max_torque);
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("stop torque above motor maximum");

   property p_zero_time;
      @(posedge clk_sys) disable iff (rst)
      (ot_any && !torque_mode &&
       stop_decel_time_param == OTS_DECEL_TIME_ZERO &&
       cfg_active.ot_stop == OTS_OT_TIME_HOLD)
      |=> stop_cmd.act == OTS_ACT_ZSPD;
   endproperty
   a_zero_time: assert property (p_zero_time)
      else $error("zero decel time did not give zero-speed stop");

   property p_servo_off;
      @(posedge clk_sys) disable iff (rst)
      (!servo_on && !warn_active) |=> !warn_active;
   endproperty
   a_servo_off: assert property (p_servo_off)
      else $error("warning raised with servo off");

   property p_hold;
      @(posedge clk_sys) disable iff (rst)
      (warn_active && !alarm_clear_command) |=> warn_active;
   endproperty
   a_hold: assert property (p_hold)
      else $error("warning dropped without clear");

   property p_opposite;
      @(posedge clk_sys) disable iff (rst)
      (!warn_active && cmd_fwd && !cmd_rev && !fwd_ot) |=> !warn_active;
   endproperty
   a_opposite: assert property (p_opposite)
      else $error("warning for limit opposite to command");

   // A disabled warning digit must keep the latch quiet.
   property p_warn_disabled;
      @(posedge clk_sys) disable iff (rst)
      (cfg_active.warn_en == OTS_WARN_OFF && !warn_active) |=> !warn_active;
   endproperty
   a_warn_disabled: assert property (p_warn_disabled)
      else $error("warning raised while detection disabled");

   // Turning the servo on must never count as an entry into overtravel.
   property p_servo_edge;
      @(posedge clk_sys) disable iff (rst)
      (!servo_on_d && !warn_active) |=> !warn_active;
   endproperty
   a_servo_edge: assert property (p_servo_edge)
      else $error("warning raised on servo turn-on");

   // Forward overtravel alone must leave reverse drive open.
   property p_escape_rev;
      @(posedge clk_sys) disable iff (rst)
      (fwd_ot && !rev_ot) |=> rev_allowed;
   endproperty
   a_escape_rev: assert property (p_escape_rev)
      else $error("reverse drive blocked by forward overtravel");

   // The zero-speed stop carries a zero speed reference.
   property p_zspd_speed;
      @(posedge clk_sys) disable iff (rst)
      (stop_cmd.act == OTS_ACT_ZSPD) |-> (stop_cmd.speed_ref == OTS_SPEED_ZERO);
   endproperty
   a_zspd_speed: assert property (p_zspd_speed)
      else $error("zero-speed stop with nonzero speed reference");

   // The reported code always matches the latched warning.
   property p_warn_code;
      @(posedge clk_sys) disable iff (rst)
      warn_active |-> (warn_code == OTS_WARN_CODE);
   endproperty
   a_warn_code: assert property (p_warn_code)
      else $error("warning code wrong while warning latched");

endmodule // ots_overtravel
`default_nettype wire

// [ots_overtravel_bench.sv]
// Self-checking testbench of the overtravel stop and warning block.
`timescale 1ns/1ps
`default_nettype none
module ots_overtravel_bench;
   import ots_pkg::*;
   logic clk_sys, rst, power_restart, servo_on, torque_mode, cmd_fwd;
   logic cmd_rev, soft_limit, alarm_clear_command, fwd_at_end, rev_at_end;
   logic forward_limit_input, reverse_limit_input, fwd_allowed, rev_allowed;
   logic warn_active;
   logic [15:0] warn_code;
   logic [9:0] estop_torq;
   logic [13:0] decel_ms;
   ots_cfg_type cfg_pending, cfg_active;
   ots_stop_type stop_cmd;
   int error_cnt = 0;
   int n_checks = 0;
   int i;
   // Stop table: ot digit, servo-off digit, torque mode, ramp time, action.
   logic [3:0] t_ot [9] = '{0, 0, 1, 2, 3, 3, 4, 3, 1};
   logic [3:0] t_so [9] = '{0, 2, 0, 0, 0, 0, 0, 2, 1};
   logic t_hz [9] = '{0, 0, 1, 0, 1, 1, 0, 0, 0};
   logic [15:0] t_sp [9] = '{0, 0, 0, 0, 16'h1000, 0, 16'h1000, 0, 0};
   logic t_tq [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
   logic [13:0] t_dc [9] = '{0, 0, 0, 0, 100, 0, 100, 100, 0};
   ots_act_type t_act [9] = '{OTS_ACT_DB, OTS_ACT_COAST, OTS_ACT_TORQ,
      OTS_ACT_TORQ, OTS_ACT_RAMP, OTS_ACT_ZSPD, OTS_ACT_RAMP, OTS_ACT_COAST,
      OTS_ACT_DB};

   ots_far_side far (.fwd_at_end, .rev_at_end, .forward_limit_input,
      .reverse_limit_input);
   ots_overtravel dut (.clk_sys, .rst, .power_restart, .cfg_pending,
      .emergency_stop_torque_param(estop_torq),
      .stop_decel_time_param(decel_ms), .motor_max_torque(10'h12C),
      .motor_max_speed(16'h2000), .motor_speed(16'h1000),
      .forward_limit_input, .reverse_limit_input, .servo_on, .torque_mode,
      .cmd_fwd, .cmd_rev, .soft_limit, .alarm_clear_command, .cfg_active,
      .fwd_allowed, .rev_allowed, .stop_cmd, .warn_active, .warn_code);

   // The 100 MHz system clock.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = !clk_sys;
   end

   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %0h seen %0h", n, e, g);
      end
   endtask

   // Selectors only load on a restart pulse, so tests that need new selectors reload them here.
   task automatic cfg(input logic [3:0] f, r, s, o, w);
      @(negedge clk_sys);
      cfg_pending = '{f, r, s, o, w};
      power_restart = 1'b1;
      @(negedge clk_sys);
      power_restart = 1'b0;
      step(1);
   endtask

   // Bounded wait; running out of it shows up as a mismatch.
   task automatic wait_warn();
      for (int k = 0; k < 8 && warn_active !== 1'b1; k++) step(1);
      chk("warn_active", 1, warn_active);
      chk("warn_code", 16'h09A0, warn_code);
   endtask

   task automatic clr();
      @(negedge clk_sys);
      alarm_clear_command = 1'b1;
      @(negedge clk_sys);
      alarm_clear_command = 1'b0;
      step(2);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      rst = 1'b1;
      {power_restart, servo_on, torque_mode, cmd_fwd, cmd_rev} = 5'h00;
      {soft_limit, alarm_clear_command, fwd_at_end, rev_at_end} = 4'h0;
      estop_torq = 10'h320;
      decel_ms = 14'h0000;
      cfg_pending = '{4'h2, 4'h3, 4'h0, 4'h0, 4'h0};
      step(16);
      chk("cfg_active", 20'h23000, cfg_active);
      chk("allowed", 2'h3, {fwd_allowed, rev_allowed});
      chk("act", OTS_ACT_RUN, stop_cmd.act);
      chk("torque_limit", 10'h320, stop_cmd.torque_limit);
      chk("warn_active", 0, warn_active);
      chk("warn_code", 0, warn_code);
      rst = 1'b0;
      step(2);
      chk("cfg_active", 20'h23000, cfg_active);
      chk("act", OTS_ACT_RUN, stop_cmd.act);
      chk("torque_limit", 10'h12C, stop_cmd.torque_limit);
      cfg_pending = '{4'h8, 4'h8, 4'h2, 4'h4, 4'h1};
      step(3);
      chk("cfg_active", 20'h23000, cfg_active);
      $display("test reset and restart latch done");
      servo_on = 1'b1;
      for (i = 0; i < 9; i++) begin
         cfg(4'h2, 4'h3, t_so[i], t_ot[i], 4'h0);
         torque_mode = t_tq[i];
         decel_ms = t_dc[i];
         fwd_at_end = 1'b1;
         step(3);
         chk("act", t_act[i], stop_cmd.act);
         chk("hold_zero", t_hz[i], stop_cmd.hold_zero);
         chk("speed_ref", t_sp[i], stop_cmd.speed_ref);
         chk("warn_active", 0, warn_active);
         fwd_at_end = 1'b0;
         step(2);
      end
      torque_mode = 1'b0;
      $display("test stop methods done");
      cfg(4'h2, 4'h3, 4'h0, 4'h1, 4'h0);
      fwd_at_end = 1'b1;
      step(3);
      chk("torque_limit", 10'h12C, stop_cmd.torque_limit);
      estop_torq = 10'h064;
      step(2);
      chk("torque_limit", 10'h064, stop_cmd.torque_limit);
      fwd_at_end = 1'b0;
      $display("test stop torque done");
      cfg(4'h2, 4'h3, 4'h0, 4'h1, 4'h1);
      fwd_at_end = 1'b1;
      wait_warn();
      chk("allowed", 2'h1, {fwd_allowed, rev_allowed});
      fwd_at_end = 1'b0;
      servo_on = 1'b0;
      step(3);
      chk("warn_active", 1, warn_active);
      clr();
      chk("warn_code", 0, warn_code);
      servo_on = 1'b1;
      step(2);
      rev_at_end = 1'b1;
      wait_warn();
      chk("allowed", 2'h2, {fwd_allowed, rev_allowed});
      clr();
      fwd_at_end = 1'b1;
      step(4);
      chk("warn_active", 0, warn_active);
      {fwd_at_end, rev_at_end} = 2'h0;
      step(2);
      rev_at_end = 1'b1;
      wait_warn();
      rev_at_end = 1'b0;
      clr();
      $display("test warning latch done");
      servo_on = 1'b0;
      fwd_at_end = 1'b1;
      step(4);
      chk("warn_active", 0, warn_active);
      servo_on = 1'b1;
      step(4);
      chk("warn_active", 0, warn_active);
      fwd_at_end = 1'b0;
      cmd_fwd = 1'b1;
      soft_limit = 1'b1;
      step(2);
      rev_at_end = 1'b1;
      step(4);
      chk("warn_active", 0, warn_active);
      fwd_at_end = 1'b1;
      wait_warn();
      chk("act", OTS_ACT_TORQ, stop_cmd.act);
      {fwd_at_end, rev_at_end, cmd_fwd} = 3'h0;
      clr();
      $display("test direction and servo state done");
      cfg(4'h8, 4'h8, 4'h0, 4'h1, 4'h1);
      {fwd_at_end, rev_at_end} = 2'h3;
      step(3);
      chk("allowed", 2'h3, {fwd_allowed, rev_allowed});
      $display("test limits ignored done");
      print_verdict();
   end
endmodule // ots_overtravel_bench
`default_nettype wire

// [ots_pkg.sv]
// Package of constants and types for the overtravel stop and warning block.
package ots_pkg;

   // Parameter code digits for the limit selectors.
   localparam logic [3:0] OTS_FWD_LIMIT_HONOUR = 4'h2;
   localparam logic [3:0] OTS_REV_LIMIT_HONOUR = 4'h3;
   localparam logic [3:0] OTS_LIMIT_IGNORE = 4'h8;

   // Servo-off stop digit codes.
   localparam logic [3:0] OTS_SOFF_DB = 4'h0;
   localparam logic [3:0] OTS_SOFF_DB_ALT = 4'h1;
   localparam logic [3:0] OTS_SOFF_COAST = 4'h2;

   // Overtravel stop digit codes.
   localparam logic [3:0] OTS_OT_FOLLOW = 4'h0;
   localparam logic [3:0] OTS_OT_TORQ_HOLD = 4'h1;
   localparam logic [3:0] OTS_OT_TORQ_FREE = 4'h2;
   localparam logic [3:0] OTS_OT_TIME_HOLD = 4'h3;
   localparam logic [3:0] OTS_OT_TIME_FREE = 4'h4;

   // Warning enable digit values.
   localparam logic [3:0] OTS_WARN_OFF = 4'h0;

   // Setting limits and reset values.
   localparam logic [9:0] OTS_ESTOP_TORQ_MAX = 10'h320;
   localparam logic [9:0] OTS_ESTOP_TORQ_RESET = 10'h320;
   localparam logic [13:0] OTS_DECEL_TIME_MAX = 14'h2710;
   localparam logic [13:0] OTS_DECEL_TIME_ZERO = 14'h0000;

   // Timing: one millisecond tick at the 100 MHz system clock.
   localparam int OTS_CLK_HZ = 100000000;
   localparam int OTS_TICK_US = 1000;
   localparam int OTS_TICK_CYCLES = OTS_CLK_HZ / 1000000 * OTS_TICK_US;
   localparam logic [16:0] OTS_TICK_LAST = 17'(OTS_TICK_CYCLES - 1);

   // Speed reference zero value.
   localparam logic [15:0] OTS_SPEED_ZERO = 16'h0000;

   // Warning code reported to the upper controller.
   localparam logic [15:0] OTS_WARN_CODE = 16'h09A0;

   // Stop action presented to the power stage.
   typedef enum logic [2:0] {
      OTS_ACT_RUN,
      OTS_ACT_DB,
      OTS_ACT_COAST,
      OTS_ACT_TORQ,
      OTS_ACT_RAMP,
      OTS_ACT_ZSPD
   } ots_act_type;

   // Power-restart latched selectors.
   typedef struct packed {
      logic [3:0] fwd_sel;
      logic [3:0] rev_sel;
      logic [3:0] soff_stop;
      logic [3:0] ot_stop;
      logic [3:0] warn_en;
   } ots_cfg_type;

   // Stop command to the drive.
   typedef struct packed {
      ots_act_type act;
      logic hold_zero;
      logic [9:0] torque_limit;
      logic [15:0] speed_ref;
   } ots_stop_type;

endpackage
